/* File: pei_top.sv */
// Pin event interrupt unit: dedicated pin and two pin-change groups
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
module pei_top
   import pei_pkg::*;
#(
   parameter int LO_PINS = PEI_LO_PINS,
   parameter int HI_PINS = PEI_HI_PINS
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire pei_bus_req_t bus_req_i,
   output logic [7:0] bus_rdata_o,
   // Core side
   input wire logic global_irq_en_i,
   input wire pei_src_t vector_ack_i,
   output pei_src_t vector_req_o,
   output logic irq_o,
   // Pins, sampled whatever their direction
   input wire logic dedicated_pin_i,
   input wire logic [LO_PINS-1:0] change_pins_lo_i,
   input wire logic [HI_PINS-1:0] change_pins_hi_i
);

   // Elaboration check on group widths
   if (LO_PINS != PEI_LO_PINS || HI_PINS != PEI_HI_PINS)
   begin : g_bad_width
      $error("pei_top: group widths must match the register layout");
   end

   // Elaboration check: flag and enable bits must sit inside one byte
   if (PEI_BIT_DED > 7 || PEI_BIT_HI > 7 || PEI_BIT_LO > 7)
   begin : g_bad_bit
      $error("pei_top: flag and enable bit positions exceed the register width");
   end

   // Elaboration check: implemented group bits agree with bit positions
   if (PEI_GRP_BITS != ((8'h01 << PEI_BIT_DED) | (8'h01 << PEI_BIT_HI)
      | (8'h01 << PEI_BIT_LO)))
   begin : g_bad_grp
      $error("pei_top: group bit mask disagrees with the bit positions");
   end

   // Elaboration check: high mask bits agree with the high pin count
   if (PEI_MASK_HI_BITS != 8'((1 << HI_PINS) - 1))
   begin : g_bad_hi_mask
      $error("pei_top: high mask bits disagree with the high pin count");
   end

   // Elaboration check: flags, enable and sense offsets differ, as do the two mask offsets
   if (PEI_OFS_FLAGS == PEI_OFS_ENABLE || PEI_OFS_SENSE == PEI_OFS_FLAGS
      || PEI_OFS_SENSE == PEI_OFS_ENABLE || PEI_OFS_MASK_LO == PEI_OFS_MASK_HI)
   begin : g_bad_ofs
      $error("pei_top: two registers share one offset");
   end

   localparam int NPIN = 1 + LO_PINS + HI_PINS;

   // Registers
   logic [7:0] pin_change_mask_low_q;
   logic [HI_PINS-1:0] pin_change_mask_high_q;
   logic [1:0] sense_control_reg_q;
   logic dedicated_irq_pin_enable_q;
   logic change_group_hi_enable_q;
   logic change_group_lo_enable_q;
   logic dedicated_irq_flag_q;
   logic change_group_hi_flag_q;
   logic change_group_lo_flag_q;
   logic [7:0] bus_rdata_q;
   pei_src_t vector_req_q;
   logic irq_q;

   // Synchroniser and history
   logic [NPIN-1:0] pins_raw;
   logic [NPIN-1:0] sync1_q;
   logic [NPIN-1:0] sync2_q;
   logic [NPIN-1:0] last_q;

   // Detection terms
   logic ded_now;
   logic ded_was;
   logic ded_event;
   logic level_mode;
   logic level_req;
   logic [LO_PINS-1:0] lo_changed;
   logic [HI_PINS-1:0] hi_changed;
   logic lo_event;
   logic hi_event;
   pei_sense_t sense;

   // Write decode
   logic wr_flags;
   logic wr_enable;
   logic wr_sense;
   logic wr_mask_lo;
   logic wr_mask_hi;
   logic clr_ded;
   logic clr_hi;
   logic clr_lo;
   pei_src_t req_d;
   logic [7:0] rdata_d;

   // Read-back words
   logic [7:0] mask_hi_word;
   logic [7:0] sense_word;
   logic [7:0] enable_word;
   logic [7:0] flags_word;

   // Pin levels gathered: bit 0 dedicated, then low group, then high group
   assign pins_raw = {change_pins_hi_i, change_pins_lo_i, dedicated_pin_i};

   // Two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   // Previous synchronised level for edge and change detection
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         last_q <= '0;
      end
      else
      begin
         last_q <= sync2_q;
      end
   end

   // Dedicated pin sense selection
   assign sense = pei_sense_t'(sense_control_reg_q);
   assign ded_now = sync2_q[0];
   assign ded_was = last_q[0];
   assign level_mode = (sense == PEI_SENSE_LOW);

   always_comb
   begin
      unique case (sense)
         PEI_SENSE_LOW: ded_event = 1'b0;
         PEI_SENSE_ANY: ded_event = ded_now ^ ded_was;
         PEI_SENSE_FALL: ded_event = ded_was & ~ded_now;
         PEI_SENSE_RISE: ded_event = ~ded_was & ded_now;
      endcase
   end

   // Low level request is a live level, no flag involved
   assign level_req = level_mode & ~ded_now;

   // Masked change detection per group
   assign lo_changed = (sync2_q[LO_PINS:1] ^ last_q[LO_PINS:1])
      & pin_change_mask_low_q[LO_PINS-1:0];
   assign hi_changed = (sync2_q[NPIN-1:LO_PINS+1] ^ last_q[NPIN-1:LO_PINS+1])
      & pin_change_mask_high_q;
   assign lo_event = |lo_changed;
   assign hi_event = |hi_changed;

   // Register write decode
   assign wr_flags = bus_req_i.wr && (bus_req_i.addr == PEI_OFS_FLAGS);
   assign wr_enable = bus_req_i.wr && (bus_req_i.addr == PEI_OFS_ENABLE);
   assign wr_sense = bus_req_i.wr && (bus_req_i.addr == PEI_OFS_SENSE);
   assign wr_mask_lo = bus_req_i.wr && (bus_req_i.addr == PEI_OFS_MASK_LO);
   assign wr_mask_hi = bus_req_i.wr && (bus_req_i.addr == PEI_OFS_MASK_HI);

   // Flag clears: write one or service entry
   assign clr_ded = (wr_flags && bus_req_i.wdata[PEI_BIT_DED]) || vector_ack_i.ded;
   assign clr_hi = (wr_flags && bus_req_i.wdata[PEI_BIT_HI]) || vector_ack_i.hi;
   assign clr_lo = (wr_flags && bus_req_i.wdata[PEI_BIT_LO]) || vector_ack_i.lo;

   // Pin change mask register, low group
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         pin_change_mask_low_q <= PEI_RST_BYTE;
      end
      else if (wr_mask_lo)
      begin
         pin_change_mask_low_q <= bus_req_i.wdata;
      end
   end

   // Pin change mask register, high group; upper bits are not stored
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         pin_change_mask_high_q <= '0;
      end
      else if (wr_mask_hi)
      begin
         pin_change_mask_high_q <= bus_req_i.wdata[HI_PINS-1:0];
      end
   end

   // Sense control register
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         sense_control_reg_q <= PEI_RST_SENSE;
      end
      else if (wr_sense)
      begin
         sense_control_reg_q <= bus_req_i.wdata[1:0];
      end
   end

   // Group enable register
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         dedicated_irq_pin_enable_q <= 1'b0;
         change_group_hi_enable_q <= 1'b0;
         change_group_lo_enable_q <= 1'b0;
      end
      else if (wr_enable)
      begin
         dedicated_irq_pin_enable_q <= bus_req_i.wdata[PEI_BIT_DED];
         change_group_hi_enable_q <= bus_req_i.wdata[PEI_BIT_HI];
         change_group_lo_enable_q <= bus_req_i.wdata[PEI_BIT_LO];
      end
   end

   // Dedicated flag: set wins over clear, held low in level mode
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         dedicated_irq_flag_q <= 1'b0;
      end
      else if (level_mode)
      begin
         dedicated_irq_flag_q <= 1'b0;
      end
      else if (ded_event)
      begin
         dedicated_irq_flag_q <= 1'b1;
      end
      else if (clr_ded)
      begin
         dedicated_irq_flag_q <= 1'b0;
      end
   end

   // High group flag: set wins over a clear in the same cycle
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         change_group_hi_flag_q <= 1'b0;
      end
      else if (hi_event)
      begin
         change_group_hi_flag_q <= 1'b1;
      end
      else if (clr_hi)
      begin
         change_group_hi_flag_q <= 1'b0;
      end
   end

   // Low group flag: set wins over a clear in the same cycle
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         change_group_lo_flag_q <= 1'b0;
      end
      else if (lo_event)
      begin
         change_group_lo_flag_q <= 1'b1;
      end
      else if (clr_lo)
      begin
         change_group_lo_flag_q <= 1'b0;
      end
   end

   // Vector requests: flag or live level, enable and global bit
   always_comb
   begin
      req_d.ded = (dedicated_irq_flag_q | level_req)
         & dedicated_irq_pin_enable_q & global_irq_en_i;
      req_d.hi = change_group_hi_flag_q & change_group_hi_enable_q
         & global_irq_en_i;
      req_d.lo = change_group_lo_flag_q & change_group_lo_enable_q
         & global_irq_en_i;
   end

   // Registered vector requests
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         vector_req_q <= '0;
      end
      else
      begin
         vector_req_q <= req_d;
      end
   end

   // Combined interrupt line, in step with the vector requests
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= |req_d;
      end
   end

   // Read-back words with reserved bits forced to zero
   assign mask_hi_word = {4'h0, pin_change_mask_high_q} & PEI_MASK_HI_BITS;
   assign sense_word = {6'h00, sense_control_reg_q} & PEI_SENSE_BITS;
   assign enable_word = {1'b0, dedicated_irq_pin_enable_q, change_group_hi_enable_q,
      change_group_lo_enable_q, 4'h0} & PEI_GRP_BITS;
   assign flags_word = {1'b0, dedicated_irq_flag_q, change_group_hi_flag_q,
      change_group_lo_flag_q, 4'h0} & PEI_GRP_BITS;

   // Read data multiplexer, reserved bits read zero
   always_comb
   begin
      rdata_d = PEI_RST_BYTE;
      if (bus_req_i.rd)
      begin
         unique case (bus_req_i.addr)
            PEI_OFS_MASK_LO: rdata_d = pin_change_mask_low_q;
            PEI_OFS_MASK_HI: rdata_d = mask_hi_word;
            PEI_OFS_SENSE: rdata_d = sense_word;
            PEI_OFS_ENABLE: rdata_d = enable_word;
            PEI_OFS_FLAGS: rdata_d = flags_word;
            default: rdata_d = PEI_RST_BYTE;
         endcase
      end
   end

   // Read data stands one cycle after the strobe
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         bus_rdata_q <= PEI_RST_BYTE;
      end
      else
      begin
         bus_rdata_q <= rdata_d;
      end
   end

   // Outputs straight from flip-flops
   assign bus_rdata_o = bus_rdata_q;
   assign vector_req_o = vector_req_q;
   assign irq_o = irq_q;

endmodule : pei_top

/* File: pei_pkg.sv */
// Constants and types for the pin event interrupt unit
package pei_pkg;

   // Register offsets on the plain register port
   localparam logic [7:0] PEI_OFS_MASK_LO = 8'h12;
   localparam logic [7:0] PEI_OFS_MASK_HI = 8'h20;
   localparam logic [7:0] PEI_OFS_SENSE = 8'h35;
   localparam logic [7:0] PEI_OFS_FLAGS = 8'h3A;
   localparam logic [7:0] PEI_OFS_ENABLE = 8'h3B;

   // Bit positions in the enable and flag registers
   localparam int PEI_BIT_DED = 6;
   localparam int PEI_BIT_HI = 5;
   localparam int PEI_BIT_LO = 4;

   // Implemented bits per register
   localparam logic [7:0] PEI_MASK_HI_BITS = 8'h0F;
   localparam logic [7:0] PEI_GRP_BITS = 8'h70;
   localparam logic [7:0] PEI_SENSE_BITS = 8'h03;

   // Reset values
   localparam logic [7:0] PEI_RST_BYTE = 8'h00;
   localparam logic [1:0] PEI_RST_SENSE = 2'h0;

   // Pin counts per group
   localparam int PEI_LO_PINS = 8;
   localparam int PEI_HI_PINS = 4;

   // Sense control encodings
   typedef enum logic [1:0]
   {
      PEI_SENSE_LOW = 2'h0,
      PEI_SENSE_ANY = 2'h1,
      PEI_SENSE_FALL = 2'h2,
      PEI_SENSE_RISE = 2'h3
   } pei_sense_t;

   // Register port request bundle
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pei_bus_req_t;

   // Per-source vector signals: dedicated, high group, low group
   typedef struct packed
   {
      logic ded;
      logic hi;
      logic lo;
   } pei_src_t;

endpackage : pei_pkg

/* File: pei_top_asserts.sv */
// Port checker for the pin event interrupt unit
`timescale 1ns/1ns
module pei_top_asserts
   import pei_pkg::*;
#(
   parameter int LO_PINS = PEI_LO_PINS,
   parameter int HI_PINS = PEI_HI_PINS
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire pei_bus_req_t bus_req_i,
   input wire logic [7:0] bus_rdata_o,
   // Core side
   input wire logic global_irq_en_i,
   input wire pei_src_t vector_ack_i,
   input wire pei_src_t vector_req_o,
   input wire logic irq_o,
   // Pins
   input wire logic [LO_PINS-1:0] change_pins_lo_i,
   input wire logic [HI_PINS-1:0] change_pins_hi_i
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   // Request, clear and read-back relations
   a_irq_mirror:
      assert property (irq_o == (vector_req_o != '0)) else $error("irq line mismatch");
   a_glob_gate:
      assert property (!$past(global_irq_en_i) |-> vector_req_o == '0)
      else $error("request without global enable");
   a_req_sticky:
      assert property ($past(vector_req_o.hi && global_irq_en_i && !vector_ack_i.hi
         && !bus_req_i.wr) && $past(!vector_ack_i.hi && !bus_req_i.wr, 2)
         |-> vector_req_o.hi) else $error("request dropped");
   a_ack_clears:
      assert property (vector_ack_i.hi && $past(change_pins_hi_i) == $past(change_pins_hi_i, 2)
         && $past(change_pins_hi_i, 2) == $past(change_pins_hi_i, 3) |-> ##2 !vector_req_o.hi)
      else $error("ack left request");
   a_wr_clears:
      assert property (bus_req_i.wr && bus_req_i.addr == PEI_OFS_FLAGS && bus_req_i.wdata[4]
         && $past(change_pins_lo_i) == $past(change_pins_lo_i, 2)
         && $past(change_pins_lo_i, 2) == $past(change_pins_lo_i, 3) |-> ##2 !vector_req_o.lo)
      else $error("write one left request");
   a_rd_idle:
      assert property (!$past(bus_req_i.rd) |-> bus_rdata_o == 8'h00) else $error("stray data");
   a_rd_hi_res:
      assert property ($past(bus_req_i.rd && bus_req_i.addr == PEI_OFS_MASK_HI)
         |-> bus_rdata_o[7:4] == 4'h0) else $error("mask high upper bits set");
   a_rd_grp_res:
      assert property ($past(bus_req_i.rd && bus_req_i.addr >= PEI_OFS_FLAGS)
         |-> (bus_rdata_o & ~PEI_GRP_BITS) == 8'h00) else $error("reserved bits set");
endmodule : pei_top_asserts

bind pei_top pei_top_asserts #(.LO_PINS(LO_PINS), .HI_PINS(HI_PINS)) u_pei_top_asserts (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o),
   .global_irq_en_i(global_irq_en_i), .vector_ack_i(vector_ack_i), .vector_req_o(vector_req_o),
   .irq_o(irq_o), .change_pins_lo_i(change_pins_lo_i), .change_pins_hi_i(change_pins_hi_i));

/* File: pei_pin_drv.sv */
// Board-side driver of the interrupt-capable pins
`timescale 1ns/1ns
module pei_pin_drv
(
   // Clock and wanted levels
   input wire logic ref_clk_i,
   input wire logic [12:0] want_i,
   // Pin levels
   output logic dedicated_pin_o,
   output logic [7:0] pins_lo_o,
   output logic [3:0] pins_hi_o
);
   logic [12:0] lvl_q = 13'h1000;

   // Levels move after an edge and stand a cycle or more
   always_ff @(posedge ref_clk_i)
   begin
      lvl_q <= want_i;
   end
   assign {dedicated_pin_o, pins_hi_o, pins_lo_o} = lvl_q;
endmodule : pei_pin_drv

/* File: tb.sv */
// Random and corner tests of the pin event interrupt unit
`timescale 1ns/1ns
module tb
   import pei_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   pei_bus_req_t breq = '0;
   logic [7:0] rdat;
   logic glob = 1'b0;
   pei_src_t ack = '0;
   pei_src_t vreq;
   logic irq;
   logic [12:0] want = 13'h1000;
   logic dpin;
   logic [7:0] plo;
   logic [3:0] phi;
   int err_total = 0;
   int checks_done = 0;
   int seed = 32'h33d2;
   int cyc = 0;
   logic [7:0] d;
   logic e;
   logic [7:0] ofs [6] = '{8'h12, 8'h20, 8'h35, 8'h3A, 8'h3B, 8'h00};
   logic [7:0] rbk [6] = '{8'hFF, 8'h0F, 8'h03, 8'h00, 8'h70, 8'h00};

   // Clock
   initial forever #50 ref_clk_i = ~ref_clk_i;

   pei_top u_pei_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_req_i(breq),
      .bus_rdata_o(rdat), .global_irq_en_i(glob), .vector_ack_i(ack), .vector_req_o(vreq),
      .irq_o(irq), .dedicated_pin_i(dpin), .change_pins_lo_i(plo), .change_pins_hi_i(phi));
   pei_pin_drv u_pei_pin_drv (.ref_clk_i(ref_clk_i), .want_i(want), .dedicated_pin_o(dpin),
      .pins_lo_o(plo), .pins_hi_o(phi));

   // Compare and report
   task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
      checks_done++;
      if (g !== x)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   // Verdict
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   // Register port cycles
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      breq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_i);
      breq.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      breq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_i);
      breq.rd <= 1'b0;
      #1 d = rdat;
   endtask : rd

   // New pin levels, then time to settle
   task automatic setp(input logic [12:0] v);
      @(posedge ref_clk_i);
      want <= v;
      repeat (6) @(posedge ref_clk_i);
   endtask : setp

   // Expected dedicated flag when the pin leaves level o
   function automatic logic exp_ded(input logic [1:0] m, input logic o);
      return (m == 2'h1) | (m == 2'h2 && o) | (m == 2'h3 && !o);
   endfunction : exp_ded

   // One pin-change group pass on a random pin
   task automatic grp(input bit hi);
      int w;
      int k;
      w = hi ? 4 : 8;
      k = $unsigned($random(seed)) % w;
      @(posedge ref_clk_i);
      glob <= 1'b0;
      wr(hi ? PEI_OFS_MASK_HI : PEI_OFS_MASK_LO, 8'(1 << k));
      wr(PEI_OFS_FLAGS, 8'h70);
      setp(want ^ 13'(1 << ((hi ? 8 : 0) + (k + 1) % w)));
      rd(PEI_OFS_FLAGS);
      chk("masked flag", 8'h00, d);
      setp(want ^ 13'(1 << ((hi ? 8 : 0) + k)));
      rd(PEI_OFS_FLAGS);
      chk("group flag", hi ? 8'h20 : 8'h10, d);
      chk("irq no global", 8'h00, {7'h00, irq});
      @(posedge ref_clk_i);
      glob <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      #1 chk("request", hi ? 8'h05 : 8'h03, {4'h0, vreq, irq});
      if (hi)
      begin
         @(posedge ref_clk_i);
         ack.hi <= 1'b1;
         @(posedge ref_clk_i);
         ack.hi <= 1'b0;
      end
      else
      begin
         wr(PEI_OFS_FLAGS, 8'h8F);
         rd(PEI_OFS_FLAGS);
         chk("zero write", 8'h10, d);
         wr(PEI_OFS_FLAGS, 8'h10);
      end
      rd(PEI_OFS_FLAGS);
      chk("cleared", 8'h00, {d[7:1], irq});
   endtask : grp

   // Main sequence
   initial
   begin
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         rd(ofs[i]);
         chk("reset value", 8'h00, d);
         wr(ofs[i], 8'hFF);
         rd(ofs[i]);
         chk("read back", rbk[i], d);
      end
      $display("register test done");
      for (int r = 0; r < 4; r++)
         grp(r[0]);
      $display("group test done");
      for (int m = 3; m >= 0; m--)
      begin
         wr(PEI_OFS_SENSE, 8'(m));
         repeat (2)
         begin
            e = exp_ded(2'(m), want[12]);
            setp(want ^ 13'h1000);
            rd(PEI_OFS_FLAGS);
            chk("dedicated flag", {1'b0, e, 6'h00}, d);
            chk("dedicated req", {7'h00, m == 0 ? !want[12] : e}, {7'h00, vreq.ded});
            wr(PEI_OFS_FLAGS, 8'h40);
         end
      end
      $display("dedicated pin test done");
      close_out();
   end

   // Hang guard
   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         err_total++;
         $display("[FAIL] cycles expected below 2000 seen %0d", cyc);
         close_out();
      end
   end
endmodule : tb
